// *** src/smsis_pkg.sv ***
// shared constants, types and register layout of the serial interface module
package smsis_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] A_CTRL0 = 8'h00;
  localparam logic [7:0] A_I2C_STAT = 8'h04;
  localparam logic [7:0] A_SADDR = 8'h08;
  localparam logic [7:0] A_DATA = 8'h0C;
  localparam logic [7:0] A_SPI_STAT = 8'h10;
  localparam logic [7:0] A_CLOCK_MODE_REG = 8'h14;

  // iface_control0 fields
  localparam int CTRL0_EN_BIT = 0;
  localparam int CTRL0_MODE_LSB = 5;
  // i2c_control_status fields
  localparam int ST_RXAK_BIT = 0;
  localparam int ST_DIR_BIT = 2;
  localparam int ST_TXAK_BIT = 3;
  localparam int ST_TXSEL_BIT = 4;
  localparam int ST_BUSY_BIT = 5;
  localparam int ST_AMATCH_BIT = 6;
  localparam int ST_BDONE_BIT = 7;
  // spi status, clock mode fields
  localparam int SPI_TRF_BIT = 0;
  localparam int CLK_PERIPH_CLOCK_OUT_ENABLE_BIT = 0;
  localparam int CLK_IDLE_BIT = 4;

  // reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] SADDR_RST = 8'h00;
  localparam logic [7:0] CLOCK_MODE_REG_RST = 8'h00;

  // spi half-period counts for the divided system clock modes
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    MODE_DIV4 = 3'b000,
    MODE_DIV16 = 3'b001,
    MODE_DIV64 = 3'b010,
    MODE_SUB = 3'b011,
    MODE_TMR = 3'b100,
    MODE_SPI_SLAVE = 3'b101,
    MODE_I2C = 3'b110,
    MODE_UNUSED = 3'b111
  } smsis_mode_t;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_AACK = 3'b010,
    I2C_RX = 3'b011,
    I2C_RACK = 3'b100,
    I2C_TX = 3'b101,
    I2C_TACK = 3'b110,
    I2C_WAIT = 3'b111
  } smsis_i2c_st_t;

  // open-drain / two-way pin drive carrier
  typedef struct packed {
    logic sda_oe_b;
    logic scl_oe_b;
    logic sck_oe_b;
    logic sdo_oe_b;
  } smsis_oe_t;

  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } smsis_tick_st_t;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] saddr;
    logic [7:0] clock_mode_reg;
    logic tx_sel;
    logic tx_ack;
    logic rx_ack;
    logic dir;
    logic busy;
    logic amatch;
    logic bdone;
    logic trf;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic spi_act;
    logic smp;
    logic sck;
    logic sdo;
    smsis_i2c_st_t ist;
    smsis_oe_t oe;
    logic sck_q;
    logic scl_q;
    logic sda_q;
    logic sub_q;
    logic [7:0] hrdata;
    logic hready;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic pclk;
    logic active;
  } smsis_st_t;

endpackage

// *** src/smsis_sync.sv ***
// two-stage synchroniser with optional glitch filter per bit
`timescale 1ns/1ps
module smsis_sync
  import smsis_pkg::*;
#(
  parameter int W = 1,
  parameter int DEB = 0,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] q;
    logic [W-1:0][1:0] cnt;
  } smsis_sync_st_t;

  smsis_sync_st_t st_r;
  smsis_sync_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_d;
    st_nxt.s2 = st_r.s1;
    for (int i = 0; i < W; i++) begin
      // a new level is accepted only after it stayed DEB extra clocks
      if (st_r.s2[i] == st_r.q[i]) begin
        st_nxt.cnt[i] = 2'h0;
      end else if (st_r.cnt[i] >= 2'(DEB)) begin
        st_nxt.q[i] = st_r.s2[i];
        st_nxt.cnt[i] = 2'h0;
      end else begin
        st_nxt.cnt[i] = st_r.cnt[i] + 2'h1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st_r <= '0;
      st_r.s1 <= RST_VAL;
      st_r.s2 <= RST_VAL;
      st_r.q <= RST_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_q = st_r.q;
endmodule

// *** src/smsis_tick.sv ***
// spi master half-period tick generator for the clock source modes
`timescale 1ns/1ps
module smsis_tick
  import smsis_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_run,
  input wire logic [2:0] i_mode,
  input wire logic i_sub_edge,
  input wire logic i_tmr_ovf,
  output logic o_tick
);
  smsis_tick_st_t st_r;
  smsis_tick_st_t st_nxt;
  logic [5:0] half;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    case (i_mode)
      MODE_DIV16: half = HALF_DIV16;
      MODE_DIV64: half = HALF_DIV64;
      default: half = HALF_DIV4;
    endcase
    if (!i_run) begin
      st_nxt.cnt = 6'h00;
    end else if (i_mode == MODE_SUB) begin
      // each sub clock transition is one half period
      st_nxt.tick = i_sub_edge;
    end else if (i_mode == MODE_TMR) begin
      // spi clock toggles per overflow, giving overflow rate / 2
      st_nxt.tick = i_tmr_ovf;
    end else if (st_r.cnt == half - 6'h01) begin
      st_nxt.cnt = 6'h00;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 6'h01;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_tick = st_r.tick;
endmodule

// *** src/smsis_top.sv ***
// serial interface module: spi master/slave and i2c slave behind an ahb-lite slave
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module smsis_top
  import smsis_pkg::*;
#(
  parameter bit P_ROUTED = 1'b1,
  parameter int P_DEBOUNCE = 0
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_idle,
  input wire logic i_halt,
  input wire logic i_sub_clk,
  input wire logic i_tmr_ovf,
  input wire logic i_serial_in_pin,
  input wire logic i_slave_select_n,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe_b,
  output logic o_sdo,
  output logic o_sdo_oe_b,
  input wire logic i_i2c_data_line,
  output logic o_i2c_data_line,
  output logic o_i2c_data_line_oe_b,
  input wire logic i_i2c_clock_line,
  output logic o_i2c_clock_line,
  output logic o_i2c_clock_line_oe_b,
  output logic o_pins_active,
  output logic o_periph_clk,
  output logic o_byte_done_irq
);
  smsis_st_t st_r;
  smsis_st_t st_nxt;
  logic [3:0] spi_s;
  logic [1:0] i2c_s;
  logic tick;
  logic sub_edge;
  logic ap;
  logic dr_rd;
  logic dr_wr;
  logic iface_enable;
  smsis_mode_t mode;
  logic is_master;
  logic en_i2c;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic sck_rise;
  logic sck_fall;

  // spi side pins: serial in, select, clock in, sub clock
  smsis_sync #(.W(4), .DEB(0), .RST_VAL(4'h4)) u_spi_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_d({i_serial_in_pin, i_slave_select_n, i_sck, i_sub_clk}),
    .o_q(spi_s)
  );

  // i2c clock and data with the build-time glitch filter
  smsis_sync #(.W(2), .DEB(P_DEBOUNCE), .RST_VAL(2'h3)) u_i2c_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_d({i_i2c_clock_line, i_i2c_data_line}),
    .o_q(i2c_s)
  );

  // halt is not an input of the shifter clocking: spi runs on through it
  smsis_tick u_tick (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_run(st_r.spi_act & is_master & (~i_idle | st_r.clock_mode_reg[CLK_IDLE_BIT])),
    .i_mode(st_r.ctrl0[CTRL0_MODE_LSB +: 3]),
    .i_sub_edge(sub_edge),
    .i_tmr_ovf(i_tmr_ovf),
    .o_tick(tick)
  );

  assign mode = smsis_mode_t'(st_r.ctrl0[CTRL0_MODE_LSB +: 3]);
  assign is_master = (mode <= MODE_TMR);
  assign iface_enable = st_r.ctrl0[CTRL0_EN_BIT] & P_ROUTED;
  assign en_i2c = st_r.active & (mode == MODE_I2C);
  assign sub_edge = spi_s[0] ^ st_r.sub_q;
  assign sck_rise = spi_s[1] & ~st_r.sck_q;
  assign sck_fall = ~spi_s[1] & st_r.sck_q;
  assign scl_rise = i2c_s[1] & ~st_r.scl_q;
  assign scl_fall = ~i2c_s[1] & st_r.scl_q;
  assign start_c = st_r.scl_q & i2c_s[1] & st_r.sda_q & ~i2c_s[0];
  assign stop_c = st_r.scl_q & i2c_s[1] & ~st_r.sda_q & i2c_s[0];
  assign ap = i_hsel & i_htrans[1] & i_hready;
  assign dr_rd = ap & ~i_hwrite & (i_haddr[7:0] == A_DATA);
  assign dr_wr = st_r.wr_pend & (st_r.wr_addr == A_DATA);

  always_comb begin
    st_nxt = st_r;
    st_nxt.hready = 1'b1;
    st_nxt.sck_q = spi_s[1];
    st_nxt.scl_q = i2c_s[1];
    st_nxt.sda_q = i2c_s[0];
    st_nxt.sub_q = spi_s[0];
    st_nxt.active = iface_enable;

    // ahb address phase: capture write target, prepare read data
    st_nxt.wr_pend = ap & i_hwrite;
    if (ap) begin
      st_nxt.wr_addr = i_haddr[7:0];
    end
    st_nxt.hrdata = 8'h00;
    if (ap && !i_hwrite) begin
      case (i_haddr[7:0])
        A_CTRL0: st_nxt.hrdata = st_r.ctrl0;
        A_I2C_STAT: st_nxt.hrdata = {st_r.bdone, st_r.amatch, st_r.busy, st_r.tx_sel,
                                     st_r.tx_ack, st_r.dir, 1'b0, st_r.rx_ack};
        A_SADDR: st_nxt.hrdata = st_r.saddr;
        A_DATA: st_nxt.hrdata = st_r.sh;
        A_SPI_STAT: st_nxt.hrdata = {7'h00, st_r.trf};
        A_CLOCK_MODE_REG: st_nxt.hrdata = st_r.clock_mode_reg;
        default: st_nxt.hrdata = 8'h00;
      endcase
    end

    // ahb data phase: register writes; clears come before hardware sets
    if (st_r.wr_pend) begin
      case (st_r.wr_addr)
        A_CTRL0: st_nxt.ctrl0 = i_hwdata[7:0];
        A_I2C_STAT: begin
          st_nxt.tx_sel = i_hwdata[ST_TXSEL_BIT];
          st_nxt.tx_ack = i_hwdata[ST_TXAK_BIT];
        end
        A_SADDR: st_nxt.saddr = i_hwdata[7:0];
        A_DATA: begin
          // a write during a running spi master byte is dropped to protect the shift
          if (!st_r.spi_act) begin
            st_nxt.sh = i_hwdata[7:0];
          end
        end
        A_SPI_STAT: begin
          if (!i_hwdata[SPI_TRF_BIT]) begin
            st_nxt.trf = 1'b0;
          end
        end
        A_CLOCK_MODE_REG: st_nxt.clock_mode_reg = i_hwdata[7:0];
        default: ;
      endcase
    end

    // peripheral clock output: fsys/2, idle gating also stops the spi master tick
    if (st_r.clock_mode_reg[CLK_PERIPH_CLOCK_OUT_ENABLE_BIT] && (!i_idle || st_r.clock_mode_reg[CLK_IDLE_BIT])) begin
      st_nxt.pclk = ~st_r.pclk;
    end else begin
      st_nxt.pclk = 1'b0;
    end

    // spi master
    if (!st_r.active || !is_master) begin
      st_nxt.spi_act = 1'b0;
      st_nxt.sck = 1'b0;
    end else if (!st_r.spi_act) begin
      if (dr_wr) begin
        st_nxt.spi_act = 1'b1;
        st_nxt.cnt = 4'h0;
        st_nxt.sck = 1'b0;
      end
    end else if (tick) begin
      if (!st_r.sck) begin
        st_nxt.sck = 1'b1;
      end else begin
        // the input lags the pin by three clocks, more than a fsys/4 half period,
        // so the bit is taken at the falling edge, once it has passed the synchroniser
        st_nxt.sck = 1'b0;
        st_nxt.sh = {st_r.sh[6:0], spi_s[3]};
        st_nxt.cnt = st_r.cnt + 4'h1;
        if (st_r.cnt == BITS_PER_BYTE - 4'h1) begin
          st_nxt.spi_act = 1'b0;
          st_nxt.trf = 1'b1;
        end
      end
    end

    // spi slave: select must be low before the master clocks
    if (st_r.active && mode == MODE_SPI_SLAVE) begin
      if (spi_s[2]) begin
        st_nxt.cnt = 4'h0;
      end else if (sck_rise) begin
        st_nxt.smp = spi_s[3];
      end else if (sck_fall) begin
        st_nxt.sh = {st_r.sh[6:0], st_r.smp};
        st_nxt.cnt = st_r.cnt + 4'h1;
        if (st_r.cnt == BITS_PER_BYTE - 4'h1) begin
          st_nxt.cnt = 4'h0;
          st_nxt.trf = 1'b1;
        end
      end
    end

    // i2c slave; it never drives a start, only answers
    if (!en_i2c) begin
      st_nxt.ist = I2C_IDLE;
      st_nxt.oe.sda_oe_b = 1'b1;
      st_nxt.oe.scl_oe_b = 1'b1;
      st_nxt.busy = 1'b0;
    end else if (start_c) begin
      st_nxt.ist = I2C_ADDR;
      st_nxt.cnt = 4'h0;
      st_nxt.busy = 1'b1;
      st_nxt.amatch = 1'b0;
      st_nxt.bdone = 1'b0;
      st_nxt.oe.sda_oe_b = 1'b1;
      st_nxt.oe.scl_oe_b = 1'b1;
    end else if (stop_c) begin
      st_nxt.ist = I2C_IDLE;
      st_nxt.busy = 1'b0;
      st_nxt.amatch = 1'b0;
      st_nxt.oe.sda_oe_b = 1'b1;
      st_nxt.oe.scl_oe_b = 1'b1;
    end else begin
      case (st_r.ist)
        I2C_IDLE: ;
        I2C_ADDR: begin
          if (scl_rise) begin
            st_nxt.sh = {st_r.sh[6:0], i2c_s[0]};
            st_nxt.cnt = st_r.cnt + 4'h1;
          end else if (scl_fall && st_r.cnt == BITS_PER_BYTE) begin
            if (st_r.sh[7:1] == st_r.saddr[7:1]) begin
              st_nxt.amatch = 1'b1;
              st_nxt.dir = st_r.sh[0];
              st_nxt.bdone = 1'b1;
              st_nxt.oe.sda_oe_b = 1'b0;
              st_nxt.ist = I2C_AACK;
            end else begin
              st_nxt.ist = I2C_IDLE;
            end
          end
        end
        I2C_AACK, I2C_RACK: begin
          if (scl_fall) begin
            st_nxt.oe.sda_oe_b = 1'b1;
            st_nxt.oe.scl_oe_b = 1'b0;
            st_nxt.ist = I2C_WAIT;
          end
        end
        I2C_WAIT: begin
          // clock held low until software reads or writes the data register
          if (dr_rd || dr_wr) begin
            st_nxt.oe.scl_oe_b = 1'b1;
            st_nxt.cnt = 4'h0;
            st_nxt.bdone = 1'b0;
            if (st_r.tx_sel) begin
              st_nxt.ist = I2C_TX;
              st_nxt.oe.sda_oe_b = st_nxt.sh[7];
            end else begin
              st_nxt.ist = I2C_RX;
            end
          end
        end
        I2C_RX: begin
          if (scl_rise) begin
            st_nxt.sh = {st_r.sh[6:0], i2c_s[0]};
            st_nxt.cnt = st_r.cnt + 4'h1;
          end else if (scl_fall && st_r.cnt == BITS_PER_BYTE) begin
            st_nxt.oe.sda_oe_b = st_r.tx_ack;
            st_nxt.bdone = 1'b1;
            st_nxt.ist = I2C_RACK;
          end
        end
        I2C_TX: begin
          if (scl_rise) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (st_r.cnt == BITS_PER_BYTE) begin
              st_nxt.oe.sda_oe_b = 1'b1;
              st_nxt.bdone = 1'b1;
              st_nxt.ist = I2C_TACK;
            end else begin
              st_nxt.sh = {st_r.sh[6:0], 1'b0};
              st_nxt.oe.sda_oe_b = st_r.sh[6];
            end
          end
        end
        I2C_TACK: begin
          if (scl_rise) begin
            st_nxt.rx_ack = i2c_s[0];
          end else if (scl_fall) begin
            if (!st_r.rx_ack) begin
              st_nxt.oe.scl_oe_b = 1'b0;
              st_nxt.ist = I2C_WAIT;
            end else begin
              st_nxt.ist = I2C_IDLE;
            end
          end
        end
        default: st_nxt.ist = I2C_IDLE;
      endcase
    end

    // spi pin drive follows mode and select
    st_nxt.oe.sck_oe_b = ~(st_r.active & is_master);
    st_nxt.oe.sdo_oe_b = ~(st_r.active & (is_master | (mode == MODE_SPI_SLAVE & ~spi_s[2])));
    st_nxt.sdo = st_nxt.sh[7];
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st_r <= '0;
      st_r.ctrl0 <= CTRL0_RST;
      st_r.saddr <= SADDR_RST;
      st_r.clock_mode_reg <= CLOCK_MODE_REG_RST;
      st_r.oe <= '1;
      st_r.hready <= 1'b1;
      st_r.scl_q <= 1'b1;
      st_r.sda_q <= 1'b1;
      st_r.rx_ack <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_hrdata = {24'h00_0000, st_r.hrdata};
  assign o_hreadyout = st_r.hready;
  assign o_hresp = st_r.wr_pend & 1'b0;
  assign o_sck = st_r.sck;
  assign o_sck_oe_b = st_r.oe.sck_oe_b;
  assign o_sdo = st_r.sdo;
  assign o_sdo_oe_b = st_r.oe.sdo_oe_b;
  // open-drain: the output level is always low, only the enable moves
  assign o_i2c_data_line = st_r.pclk & 1'b0;
  assign o_i2c_data_line_oe_b = st_r.oe.sda_oe_b;
  assign o_i2c_clock_line = st_r.pclk & 1'b0;
  assign o_i2c_clock_line_oe_b = st_r.oe.scl_oe_b;
  assign o_pins_active = st_r.active;
  assign o_periph_clk = st_r.pclk;
  assign o_byte_done_irq = st_r.bdone;
endmodule

// *** sim/smsis_top_props.sv ***
// port-level assertions for the serial interface module
`timescale 1ns/1ps
module smsis_top_props (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_idle,
  input wire logic i_i2c_clock_line,
  input wire logic o_sck,
  input wire logic o_sck_oe_b,
  input wire logic o_sdo,
  input wire logic o_sdo_oe_b,
  input wire logic o_i2c_data_line,
  input wire logic o_i2c_data_line_oe_b,
  input wire logic o_i2c_clock_line,
  input wire logic o_i2c_clock_line_oe_b,
  input wire logic o_pins_active,
  input wire logic o_byte_done_irq
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  open_drain_a: assert property (!o_i2c_data_line && !o_i2c_clock_line)
    else $error("i2c pin drives a high level");
  float_off_a: assert property ((!o_pins_active) [*2] |-> o_i2c_data_line_oe_b && o_i2c_clock_line_oe_b
    && o_sck_oe_b && o_sdo_oe_b)
    else $error("pin driven while interface off");
  irq_on_low_a: assert property ($rose(o_byte_done_irq) |-> !i_i2c_clock_line)
    else $error("byte done outside a low clock phase");
  sda_in_low_a: assert property ($fell(o_i2c_data_line_oe_b) |-> !i_i2c_clock_line)
    else $error("data pulled low while clock high");
  scl_stretch_a: assert property ($fell(o_i2c_clock_line_oe_b) |-> !i_i2c_clock_line)
    else $error("slave pulled a high clock low");
  sck_driven_a: assert property ($changed(o_sck) |-> !o_sck_oe_b)
    else $error("spi clock moves while not driven");
  sck_half_a: assert property ($rose(o_sck) |=> o_sck)
    else $error("spi clock high phase too short");
  sdo_hold_a: assert property (o_sck && $past(o_sck) |-> $stable(o_sdo))
    else $error("spi data changed while clock high");
  sck_runs_a: assert property ($rose(o_sck) && !i_idle |-> ##[1:40] !o_sck)
    else $error("spi clock stalled");
endmodule

bind smsis_top smsis_top_props smsis_top_props_inst (.i_mclk, .i_rst_b, .i_idle, .i_i2c_clock_line, .o_sck,
  .o_sck_oe_b, .o_sdo, .o_sdo_oe_b, .o_i2c_data_line, .o_i2c_data_line_oe_b, .o_i2c_clock_line,
  .o_i2c_clock_line_oe_b, .o_pins_active, .o_byte_done_irq);

// *** sim/smsis_i2c_master.sv ***
// i2c bus master model on the open-drain lines
`timescale 1ns/1ps
module smsis_i2c_master #(
  parameter int HALF = 12
) (
  input wire logic i_mclk,
  input wire logic i_sda,
  input wire logic i_scl,
  output logic o_sda,
  output logic o_scl
);
  initial begin
    o_sda = 1'b1;
    o_scl = 1'b1;
  end
  task automatic gap();
    repeat (HALF) @(posedge i_mclk);
  endtask
  // the slave may stretch the low phase, so wait for the line itself
  task automatic scl_up();
    o_scl <= 1'b1;
    @(posedge i_mclk);
    while (i_scl !== 1'b1) @(posedge i_mclk);
    gap();
  endtask
  task automatic start();
    o_sda <= 1'b0;
    gap();
    o_scl <= 1'b0;
    gap();
  endtask
  task automatic stop();
    o_sda <= 1'b0;
    gap();
    scl_up();
    o_sda <= 1'b1;
    gap();
  endtask
  task automatic put_bit(input logic b, output logic r);
    o_sda <= b;
    gap();
    scl_up();
    r = i_sda;
    o_scl <= 1'b0;
    gap();
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] got, output logic ack_in);
    for (int i = 7; i >= 0; i--) put_bit(d[i], got[i]);
    put_bit(ack, ack_in);
  endtask
endmodule

// *** sim/tb.sv ***
// self-checking bench for the serial interface module
`timescale 1ns/1ps
module tb;
  import smsis_pkg::*;
  logic i_mclk, i_rst_b, hsel, hwrite, idle, halt, m_sda, m_scl, ak, sck_m, ss_n;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hresp, sck, sck_oe_b, sdo, sdo_oe_b, sda_o, sda_oe_b, scl_o, scl_oe_b, pins, pclk, irq;
  logic [7:0] spi_in, sdo_cap, sa, d, e, ib;
  logic [7:0] regs [0:5];
  wire hready;
  wire sda = m_sda & (sda_oe_b | sda_o);
  wire scl = m_scl & (scl_oe_b | scl_o);
  int err_count, total_checks, seed, n;

  smsis_top #(.P_DEBOUNCE(2)) smsis_top_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_idle(idle), .i_halt(halt), .i_sub_clk(1'b0),
    .i_tmr_ovf(1'b0), .i_serial_in_pin(spi_in[7]), .i_slave_select_n(ss_n), .i_sck(sck_m), .o_sck(sck),
    .o_sck_oe_b(sck_oe_b), .o_sdo(sdo), .o_sdo_oe_b(sdo_oe_b), .i_i2c_data_line(sda), .o_i2c_data_line(sda_o),
    .o_i2c_data_line_oe_b(sda_oe_b), .i_i2c_clock_line(scl), .o_i2c_clock_line(scl_o),
    .o_i2c_clock_line_oe_b(scl_oe_b), .o_pins_active(pins), .o_periph_clk(pclk), .o_byte_done_irq(irq));
  smsis_i2c_master smsis_i2c_master_inst (.i_mclk(i_mclk), .i_sda(sda), .i_scl(scl), .o_sda(m_sda), .o_scl(m_scl));

  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  // far spi device on the design's clock in master mode, on the bench's in slave mode:
  // takes a bit at once on the rising clock, puts the next out at once on the falling one
  wire sclk = sck | sck_m;
  always @(posedge sclk) sdo_cap <= {sdo_cap[6:0], sdo};
  always @(negedge sclk) spi_in <= {spi_in[6:0], ~spi_in[7]};

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_rdy();
    @(posedge i_mclk);
    while (hready !== 1'b1) @(posedge i_mclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= 32'(wd);
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    bus(1'b1, a, wd, v);
    if (a <= A_CLOCK_MODE_REG) regs[a[4:2]] = wd;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, v);
    chk(v, exp);
  endtask

  initial begin
    seed = 54194;
    {err_count, total_checks} = '0;
    {i_rst_b, hsel, hwrite, idle, halt, sck_m} = '0;
    ss_n = 1'b1;
    {haddr, hwdata, htrans, spi_in, sdo_cap} = '0;
    hsize = 3'b010;
    regs = '{default: 8'h00};
    repeat (10) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_mclk);
    rd(A_I2C_STAT, 32'h0000_0001);
    rd(8'h1C, 32'h0000_0000);
    chk(32'(hresp), 32'h0000_0000);
    chk(32'({pins, sda_oe_b, scl_oe_b, sck_oe_b, sdo_oe_b}), 32'h0000_000F);
    sa = 8'($random(seed)) & 8'hFE;
    wr(A_SADDR, sa);
    wr(A_CLOCK_MODE_REG, 8'h11);
    wr(A_CTRL0, 8'hC0);
    foreach (regs[i]) if (i != 1 && i != 4) rd(8'(i * 4), 32'(regs[i]));
    chk(32'(pins), 32'h0000_0000);
    @(posedge i_mclk) n = pclk;
    @(posedge i_mclk) chk(32'(pclk), 32'(n == 0));
    $display("test registers done");
    for (int m = 0; m < 3; m++) begin
      halt <= m[0];
      wr(A_CTRL0, 8'(m * 32 + 1));
      d = 8'($random(seed));
      ib = 8'($random(seed));
      spi_in <= ib;
      wr(A_DATA, d);
      e = ~d;
      wr(A_DATA, e);
      v = '0;
      while (v[0] !== 1'b1) begin
        bus(1'b0, A_SPI_STAT, 8'h00, v);
      end
      chk(32'(sdo_cap), 32'(d));
      rd(A_DATA, 32'(ib));
      rd(A_SPI_STAT, 32'h0000_0001);
      wr(A_SPI_STAT, 8'h00);
      rd(A_SPI_STAT, 32'h0000_0000);
    end
    $display("test spi master done");
    wr(A_CTRL0, 8'hA1);
    d = 8'($random(seed));
    ib = 8'($random(seed));
    spi_in <= ib;
    wr(A_DATA, d);
    ss_n <= 1'b0;
    repeat (8) @(posedge i_mclk);
    repeat (16) begin
      sck_m <= ~sck_m;
      repeat (8) @(posedge i_mclk);
    end
    chk(32'(sdo_oe_b), 32'h0000_0000);
    ss_n <= 1'b1;
    chk(32'(sdo_cap), 32'(d));
    rd(A_DATA, 32'(ib));
    rd(A_SPI_STAT, 32'h0000_0001);
    wr(A_SPI_STAT, 8'h00);
    $display("test spi slave done");
    halt <= 1'b0;
    idle <= 1'b1;
    wr(A_CLOCK_MODE_REG, 8'h10);
    wr(A_I2C_STAT, 8'h00);
    wr(A_CTRL0, 8'hC1);
    smsis_i2c_master_inst.start();
    smsis_i2c_master_inst.xfer({sa[7:1], 1'b0}, 1'b1, ib, ak);
    chk(32'(ak), 32'h0000_0000);
    rd(A_I2C_STAT, 32'h0000_00E1);
    chk(32'({irq, pclk}), 32'h0000_0002);
    bus(1'b0, A_DATA, 8'h00, v);
    d = 8'($random(seed));
    smsis_i2c_master_inst.xfer(d, 1'b1, ib, ak);
    chk(32'(ak), 32'h0000_0000);
    rd(A_DATA, 32'(d));
    wr(A_I2C_STAT, 8'h08);
    e = ~d;
    smsis_i2c_master_inst.xfer(e, 1'b1, ib, ak);
    chk(32'(ak), 32'h0000_0001);
    rd(A_DATA, 32'(e));
    smsis_i2c_master_inst.stop();
    bus(1'b0, A_I2C_STAT, 8'h00, v);
    chk(v & 32'h0000_0060, 32'h0000_0000);
    $display("test i2c receive done");
    wr(A_I2C_STAT, 8'h00);
    smsis_i2c_master_inst.start();
    smsis_i2c_master_inst.xfer({sa[7:1], 1'b1}, 1'b1, ib, ak);
    chk(32'(ak), 32'h0000_0000);
    rd(A_I2C_STAT, 32'h0000_00E5);
    wr(A_I2C_STAT, 8'h10);
    for (int k = 0; k < 2; k++) begin
      d = 8'($random(seed));
      wr(A_DATA, d);
      smsis_i2c_master_inst.xfer(8'hFF, k[0], ib, ak);
      chk(32'(ib), 32'(d));
      rd(A_I2C_STAT, 32'h0000_00F4 | 32'(k));
    end
    chk(32'(sda_oe_b), 32'h0000_0001);
    smsis_i2c_master_inst.stop();
    $display("test i2c transmit done");
    smsis_i2c_master_inst.start();
    smsis_i2c_master_inst.xfer({~sa[7:1], 1'b0}, 1'b1, ib, ak);
    chk(32'(ak), 32'h0000_0001);
    bus(1'b0, A_I2C_STAT, 8'h00, v);
    chk(v & 32'h0000_0060, 32'h0000_0020);
    smsis_i2c_master_inst.stop();
    $display("test i2c other address done");
    idle <= 1'b0;
    wr(A_CTRL0, 8'hC0);
    repeat (2) @(posedge i_mclk);
    chk(32'({pins, sda_oe_b, scl_oe_b, sck_oe_b, sdo_oe_b}), 32'h0000_000F);
    $display("test disable done");
    conclude();
  end

  // bound on the whole run: the longest test needs about a thousand cycles
  initial begin
    repeat (40000) @(posedge i_mclk);
    err_count++;
    conclude();
  end
endmodule
